// ===== verilog/hs_select_defs.svh
// What this block does
// - Bit 6 at 0: supply overvoltage turns all four switches off; at 1: no shutdown.
// - Bit 5 at 0: supply undervoltage turns all four switches off; at 1: no shutdown.
// - Bit 4 at 1: switches resume prior state after supply fault; at 0: no recovery.
// - Shutdown register bits 7 and 3:0 always read zero.
// - Source codes: off, on, timer 1, timer 2, duty 1, duty 2, 110/111 reserved.
// - Switches 1 and 3 use bits 2:0, switches 2 and 4 bits 6:4.
// - Overcurrent or overtemperature clears that switch's source field.
// - Third fault output duty from bits 7:6: 20, 10, 5, 2.5 percent.
// - Pin 2 bits 5:3: 0xx fault 3, off, wake 16us, low-side on, high-side on.
// - Pin 1 bits 2:0 decode like pin 2, but 0xx selects fault output 2.
// - Duty value 0 fully off, 255 fully on, else value/255 of period.
// - Timer source with on-time code 000 holds the switch low.
// Purpose: register offsets, field positions and counts
// Assumes: 7-bit register addresses, 8-bit data
// Notes:   definitions only
`ifndef HS_SELECT_DEFS_SVH
`define HS_SELECT_DEFS_SVH
// ==========================================
// Register offsets
`define SSC_ADDR 7'h10
`define HSA_ADDR 7'h14
`define HSB_ADDR 7'h15
`define MPC_ADDR 7'h17
// ==========================================
// Field positions
`define SSC_OV_BIT 6
`define SSC_UV_BIT 5
`define SSC_REC_BIT 4
`define SRC_LO_MSB 2
`define SRC_LO_LSB 0
`define SRC_HI_MSB 6
`define SRC_HI_LSB 4
`define FAULT_OUT_DUTY_SELECT_MSB 7
`define FAULT_OUT_DUTY_SELECT_LSB 6
`define PIN2_MSB 5
`define PIN2_LSB 3
`define PIN1_MSB 2
`define PIN1_LSB 0
// ==========================================
// Reset values and counts
`define REG_RESET 8'h00
`define SRC_RESET 3'h0
`define TIMER_IDLE 3'h0
`define DUTY_FULL 8'hFF
`define DUTY_LAST 8'hFE
`define FO_LAST 6'h27
`define FO_ON_20 6'h08
`define FO_ON_10 6'h04
`define FO_ON_5 6'h02
`define FO_ON_2P5 6'h01
`endif

// ===== verilog/hs_select_pkg.sv
// Purpose: shared types of the high-side select block
// Assumes: header holds the numbers
// Notes:   none
package hs_select_pkg;
    // Switch source codes, in encoding order
    typedef enum logic [2:0] {
        SRC_OFF, SRC_ON, SRC_FIRST_CYCLIC_TIMER, SRC_SECOND_CYCLIC_TIMER, SRC_DUTY1, SRC_DUTY2, SRC_RSV6, SRC_RSV7
    } src_t;
    // Decoded multipurpose pin modes
    typedef enum {PIN_FAULT, PIN_OFF, PIN_WAKE, PIN_LOW, PIN_HIGH} pinMode_t;
endpackage

// ===== verilog/duty_link.sv
// Purpose: carrier between select logic and a duty generator
// Assumes: single clock
// Notes:   none
`timescale 1ns/1ps
interface duty_link;
    logic [7:0] duty;
    logic       level;
    modport gen  (input duty, output level);
    modport user (output duty, input level);
endinterface

// ===== verilog/duty_gen.sv
// Purpose: 255-step duty generator
// Assumes: duty stable or changing at any time
// Notes:   PRESCALE stretches each step
`timescale 1ns/1ps
`include "hs_select_defs.svh"
module duty_gen #(
    parameter int PRESCALE = 4
) (
    input  wire logic clk,
    input  wire logic rst,
    duty_link.gen     link
);
    // Prescaler counter is 16 bits wide, so larger values would never wrap
    if (PRESCALE < 1 || PRESCALE > 65536) begin : badPrescale
        $error("PRESCALE must be 1 to 65536");
    end
    logic [15:0] pre;
    logic [7:0]  step;
    // ==========================================
    // Step counter, 255 steps 0..254 per period
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            pre  <= 16'h0000;
            step <= 8'h00;
        end else if (pre == 16'(PRESCALE - 1)) begin
            pre  <= 16'h0000;
            step <= (step == `DUTY_LAST) ? 8'h00 : step + 8'h01;
        end else begin
            pre <= pre + 16'h0001;
        end
    end
    // Full scale is also tested directly, though step < 255 already holds on all 255 steps
    always_ff @(posedge clk or posedge rst) begin
        if (rst) link.level <= 1'b0;
        else     link.level <= (link.duty == `DUTY_FULL) || (step < link.duty);
    end
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    zeroDuty_off_a: assert property ((link.duty == 8'h00) |=> !link.level)
        else $error("duty 0 drove output on");
    fullDuty_on_a: assert property ((link.duty == 8'hFF) |=> link.level)
        else $error("duty 255 left output off");
endmodule // duty_gen

// ===== verilog/high_side_output_select.sv
// Purpose: register bank and output selection for four switches and two pins
// Assumes: register strobe and timer levels from logic on clk; fault pins asynchronous
// Notes:   read data appears one cycle after the address
`timescale 1ns/1ps
`include "hs_select_defs.svh"
module high_side_output_select
    import hs_select_pkg::*;
#(
    parameter int DUTY_PRESCALE = 4,
    parameter int FO_PRESCALE   = 4
) (
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       softReset,
    input  wire logic       restartReq,
    input  wire logic       wrEn,
    input  wire logic [6:0] addr,
    input  wire logic [7:0] wrData,
    output logic      [7:0] rdData,
    input  wire logic       supplyOvPin,
    input  wire logic       supplyUvPin,
    input  wire logic [3:0] overloadPin,
    input  wire logic [1:0] timerLevel,
    input  wire logic [2:0] timer1OnCode,
    input  wire logic [2:0] timer2OnCode,
    input  wire logic [7:0] duty1,
    input  wire logic [7:0] duty2,
    input  wire logic       faultLevel2,
    input  wire logic       faultLevel3,
    output logic      [3:0] switchOut,
    output logic            pin1Fault,
    output logic            pin1Wake,
    output logic            pin1LowSide,
    output logic            pin1HighSide,
    output logic            pin2Fault,
    output logic            pin2Wake,
    output logic            pin2LowSide,
    output logic            pin2HighSide
);
    // Prescaler counter is 16 bits wide, so larger values would never wrap
    if (FO_PRESCALE < 1 || FO_PRESCALE > 65536) begin : badFoPrescale
        $error("FO_PRESCALE must be 1 to 65536");
    end
    // ==========================================
    // Asynchronous fault inputs, two flops each
    logic [5:0] sync1;
    logic [5:0] sync2;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
        end else begin
            sync1 <= {supplyOvPin, supplyUvPin, overloadPin};
            sync2 <= sync1;
        end
    end
    logic       ovSeen;
    logic       uvSeen;
    logic [3:0] overload;
    assign ovSeen   = sync2[5];
    assign uvSeen   = sync2[4];
    assign overload = sync2[3:0];
    // ==========================================
    // Registers
    logic [2:0] sdCtrl;   // {ovDisable, uvDisable, recovery}
    src_t       src [4];
    logic [7:0] pinCtrl;
    logic       ovDis;
    logic       uvDis;
    logic       recover;
    logic       shutdown;
    assign ovDis    = sdCtrl[2];
    assign uvDis    = sdCtrl[1];
    assign recover  = sdCtrl[0];
    assign shutdown = (ovSeen && !ovDis) || (uvSeen && !uvDis);
    // Shutdown and pin settings survive a restart, only full resets clear them
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            sdCtrl  <= 3'h0;
            pinCtrl <= `REG_RESET;
        end else if (softReset) begin
            sdCtrl  <= 3'h0;
            pinCtrl <= `REG_RESET;
        end else if (restartReq) begin
            sdCtrl  <= sdCtrl;
        end else if (wrEn && addr == `SSC_ADDR) begin
            sdCtrl <= {wrData[`SSC_OV_BIT], wrData[`SSC_UV_BIT], wrData[`SSC_REC_BIT]};
        end else if (wrEn && addr == `MPC_ADDR) begin
            pinCtrl <= wrData;
        end
    end
    // Source fields; hardware clears win over a write in the same cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < 4; i++) src[i] <= SRC_OFF;
        end else begin
            for (int i = 0; i < 4; i++) begin
                if (softReset || restartReq) begin
                    src[i] <= SRC_OFF;
                end else if (overload[i]) begin
                    src[i] <= SRC_OFF;
                end else if (shutdown && !recover) begin
                    src[i] <= SRC_OFF;
                end else if (wrEn && addr == ((i < 2) ? `HSA_ADDR : `HSB_ADDR)) begin
                    src[i] <= (i % 2 == 0) ? src_t'(wrData[`SRC_LO_MSB:`SRC_LO_LSB])
                                           : src_t'(wrData[`SRC_HI_MSB:`SRC_HI_LSB]);
                end
            end
        end
    end
    // ==========================================
    // Register read, reserved bits as zero
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdData <= `REG_RESET;
        end else begin
            unique case (addr)
                `SSC_ADDR: rdData <= {1'b0, sdCtrl, 4'h0};
                `HSA_ADDR: rdData <= {1'b0, src[1], 1'b0, src[0]};
                `HSB_ADDR: rdData <= {1'b0, src[3], 1'b0, src[2]};
                `MPC_ADDR: rdData <= pinCtrl;
                default:   rdData <= `REG_RESET;
            endcase
        end
    end
    // ==========================================
    // Duty generators
    duty_link dl1 ();
    duty_link dl2 ();
    assign dl1.duty = duty1;
    assign dl2.duty = duty2;
    duty_gen #(.PRESCALE(DUTY_PRESCALE)) dutyA (.clk(clk), .rst(rst), .link(dl1));
    duty_gen #(.PRESCALE(DUTY_PRESCALE)) dutyB (.clk(clk), .rst(rst), .link(dl2));
    // ==========================================
    // Source selection; a stopped timer keeps its switch dark
    function automatic logic srcLevel(input src_t s);
        unique case (s)
            SRC_OFF:    srcLevel = 1'b0;
            SRC_ON:     srcLevel = 1'b1;
            SRC_FIRST_CYCLIC_TIMER: srcLevel = timerLevel[0] && (timer1OnCode != `TIMER_IDLE);
            SRC_SECOND_CYCLIC_TIMER: srcLevel = timerLevel[1] && (timer2OnCode != `TIMER_IDLE);
            SRC_DUTY1:  srcLevel = dl1.level;
            SRC_DUTY2:  srcLevel = dl2.level;
            SRC_RSV6,
            SRC_RSV7:   srcLevel = 1'b0;
        endcase
    endfunction
    // Outputs drop on a fault on the same edge as the field clear
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            switchOut <= 4'h0;
        end else begin
            for (int i = 0; i < 4; i++) begin
                switchOut[i] <= !shutdown && !overload[i] && srcLevel(src[i]);
            end
        end
    end
    // ==========================================
    // Third fault output duty: 40 steps per period
    logic [15:0] foPre;
    logic [5:0]  foStep;
    logic [5:0]  foOn;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            foPre  <= 16'h0000;
            foStep <= 6'h00;
        end else if (foPre == 16'(FO_PRESCALE - 1)) begin
            foPre  <= 16'h0000;
            foStep <= (foStep == `FO_LAST) ? 6'h00 : foStep + 6'h01;
        end else begin
            foPre <= foPre + 16'h0001;
        end
    end
    always_comb begin
        unique case (pinCtrl[`FAULT_OUT_DUTY_SELECT_MSB:`FAULT_OUT_DUTY_SELECT_LSB])
            2'b00: foOn = `FO_ON_20;
            2'b01: foOn = `FO_ON_10;
            2'b10: foOn = `FO_ON_5;
            2'b11: foOn = `FO_ON_2P5;
        endcase
    end
    // ==========================================
    // Multipurpose pin decode
    function automatic pinMode_t pinMode(input logic [2:0] c);
        if (!c[2])         pinMode = PIN_FAULT;
        else if (c == 3'h4) pinMode = PIN_OFF;
        else if (c == 3'h5) pinMode = PIN_WAKE;
        else if (c == 3'h6) pinMode = PIN_LOW;
        else               pinMode = PIN_HIGH;
    endfunction
    pinMode_t mode1;
    pinMode_t mode2;
    assign mode1 = pinMode(pinCtrl[`PIN1_MSB:`PIN1_LSB]);
    assign mode2 = pinMode(pinCtrl[`PIN2_MSB:`PIN2_LSB]);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            {pin1Fault, pin1Wake, pin1LowSide, pin1HighSide} <= 4'h0;
            {pin2Fault, pin2Wake, pin2LowSide, pin2HighSide} <= 4'h0;
        end else begin
            pin1Fault    <= (mode1 == PIN_FAULT) && faultLevel2;
            pin1Wake     <= mode1 == PIN_WAKE;
            pin1LowSide  <= mode1 == PIN_LOW;
            pin1HighSide <= mode1 == PIN_HIGH;
            pin2Fault    <= (mode2 == PIN_FAULT) && faultLevel3 && (foStep < foOn);
            pin2Wake     <= mode2 == PIN_WAKE;
            pin2LowSide  <= mode2 == PIN_LOW;
            pin2HighSide <= mode2 == PIN_HIGH;
        end
    end
    // ==========================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    ovShutdown_a: assert property ((ovSeen && !ovDis) |=> switchOut == 4'h0)
        else $error("overvoltage left a switch on");
    uvShutdown_a: assert property ((uvSeen && !uvDis) |=> switchOut == 4'h0)
        else $error("undervoltage left a switch on");
    noRecover_a: assert property ((shutdown && !recover && !wrEn) |=> src[0] == SRC_OFF)
        else $error("source kept without recovery");
    sscReserved_a: assert property ((addr == `SSC_ADDR) |=> rdData[7] == 1'b0 && rdData[3:0] == 4'h0)
        else $error("reserved shutdown bits read nonzero");
    sequence onWritten;
        // A hardware clear in the same cycle would win over the write
        wrEn && addr == `HSA_ADDR && wrData[`SRC_HI_MSB:`SRC_HI_LSB] == SRC_ON
            && !softReset && !restartReq && !shutdown && !overload[1];
    endsequence
    sequence stillOn;
        !shutdown && !overload[1] && !softReset && !restartReq;
    endsequence
    onSource_a: assert property (onWritten ##1 stillOn |=> switchOut[1])
        else $error("on code did not drive switch 2");
    reservedOff_a: assert property ((src[0] == SRC_RSV6 || src[0] == SRC_RSV7) |=> !switchOut[0])
        else $error("reserved code drove switch");
    overloadClr_a: assert property (overload[2] |=> src[2] == SRC_OFF && !switchOut[2])
        else $error("overload did not clear source");
    timerIdle_a: assert property ((src[3] == SRC_FIRST_CYCLIC_TIMER && timer1OnCode == 3'h0) |=> !switchOut[3])
        else $error("idle timer drove switch");
    restartKeep_a: assert property ((restartReq && !softReset) |=> pinCtrl == $past(pinCtrl))
        else $error("restart changed pin settings");
    pinHigh_a: assert property ((pinCtrl[2:0] == 3'h7) |=> pin1HighSide && !pin1Wake)
        else $error("pin 1 high-side not selected");
    pinWake_a: assert property ((pinCtrl[5:3] == 3'h5) |=> pin2Wake && !pin2Fault)
        else $error("pin 2 wake not selected");
endmodule // high_side_output_select

// ===== dv/load_model.sv
// Purpose: external loads and switch supply around the select block
// Assumes: bench commands shorts and supply faults as levels
// Notes:   a short only shows while its switch really drives
`timescale 1ns/1ps
module load_model (
    input  wire logic [3:0] switchOut,
    input  wire logic [3:0] shortCmd,
    input  wire logic       ovCmd,
    input  wire logic       uvCmd,
    output logic      [3:0] overloadPin,
    output logic            supplyOvPin,
    output logic            supplyUvPin
);
    // ==========================================
    // Load and supply behaviour
    // A shorted load draws no current from a switch that is off
    assign overloadPin = shortCmd & switchOut;
    // Supply faults follow the bench command directly
    assign supplyOvPin = ovCmd;
    assign supplyUvPin = uvCmd;
endmodule // load_model

// ===== dv/tb_top.sv
// Purpose: self-checking bench for the high-side select register bank
// Assumes: short prescalers so duty patterns fit in 255 cycles or fewer
// Notes:   expected values come from the field encodings only
`timescale 1ns/1ps
`include "hs_select_defs.svh"
module tb_top
    import hs_select_pkg::*;
;
    logic       clk, rst, softReset, restartReq, wrEn, ovCmd, uvCmd, faultLevel2, faultLevel3;
    logic [6:0] addr;
    logic [7:0] wrData, rdData, duty1, duty2, v, cnt;
    logic [3:0] switchOut, overloadPin, shortCmd;
    logic [2:0] timer1OnCode, timer2OnCode;
    logic [1:0] timerLevel;
    logic       supplyOvPin, supplyUvPin, e;
    logic       pin1Fault, pin1Wake, pin1LowSide, pin1HighSide;
    logic       pin2Fault, pin2Wake, pin2LowSide, pin2HighSide;
    int         n_fail, n_checks, d;
    high_side_output_select #(.DUTY_PRESCALE(1), .FO_PRESCALE(1)) dut (
        .clk(clk), .rst(rst), .softReset(softReset), .restartReq(restartReq),
        .wrEn(wrEn), .addr(addr), .wrData(wrData), .rdData(rdData),
        .supplyOvPin(supplyOvPin), .supplyUvPin(supplyUvPin), .overloadPin(overloadPin),
        .timerLevel(timerLevel), .timer1OnCode(timer1OnCode), .timer2OnCode(timer2OnCode),
        .duty1(duty1), .duty2(duty2), .faultLevel2(faultLevel2), .faultLevel3(faultLevel3),
        .switchOut(switchOut), .pin1Fault(pin1Fault), .pin1Wake(pin1Wake),
        .pin1LowSide(pin1LowSide), .pin1HighSide(pin1HighSide), .pin2Fault(pin2Fault),
        .pin2Wake(pin2Wake), .pin2LowSide(pin2LowSide), .pin2HighSide(pin2HighSide));
    load_model loads (.switchOut(switchOut), .shortCmd(shortCmd), .ovCmd(ovCmd),
        .uvCmd(uvCmd), .overloadPin(overloadPin), .supplyOvPin(supplyOvPin),
        .supplyUvPin(supplyUvPin));
    // ==========================================
    // Clock and shared tasks
    always #10 clk = ~clk;
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Write strobe held one edge, then dropped
    task automatic wr(input logic [6:0] a, input logic [7:0] dat);
        @(posedge clk);
        wrEn   <= 1'b1;
        addr   <= a;
        wrData <= dat;
        @(posedge clk);
        wrEn   <= 1'b0;
    endtask
    // Read data is registered, so sample one edge after the address
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        @(posedge clk);
        #1 check("rdData", rdData, exp);
    endtask
    // Covers the two sync flops plus the output flop with margin
    task automatic settle;
        repeat (6) @(posedge clk);
        #1;
    endtask
    task automatic all_zero;
        rd(`SSC_ADDR, 8'h00);
        rd(`HSA_ADDR, 8'h00);
        rd(`HSB_ADDR, 8'h00);
        rd(`MPC_ADDR, 8'h00);
    endtask
    // Switch 1 on, apply a supply fault, then remove it
    task automatic supply_case(input logic [7:0] ssc, input logic ov, input logic uv,
                               input logic [7:0] src, input logic onIn, input logic onOut);
        wr(`SSC_ADDR, ssc);
        wr(`HSA_ADDR, 8'h01);
        @(posedge clk);
        ovCmd <= ov;
        uvCmd <= uv;
        settle();
        check("switchOut0", {7'h00, switchOut[0]}, {7'h00, onIn});
        rd(`HSA_ADDR, src);
        @(posedge clk);
        ovCmd <= 1'b0;
        uvCmd <= 1'b0;
        settle();
        check("switchOut0", {7'h00, switchOut[0]}, {7'h00, onOut});
        wr(`HSA_ADDR, 8'h00);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Watchdog: whole run needs about a thousand cycles
    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        results();
    end
    // ==========================================
    // Main sequence
    initial begin
        {clk, softReset, restartReq, wrEn, ovCmd, uvCmd, faultLevel3} = '0;
        {addr, wrData, shortCmd, timer2OnCode} = '0;
        rst = 1'b1;
        faultLevel2 = 1'b1;
        timerLevel = 2'b01;
        timer1OnCode = 3'h1;
        duty1 = 8'hFF;
        duty2 = 8'h00;
        n_fail = 0;
        n_checks = 0;
        timer2OnCode = 3'h1;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        all_zero();
        // Reserved bits read zero, unmapped address ignored
        wr(`SSC_ADDR, 8'hFF);
        rd(`SSC_ADDR, 8'h70);
        wr(`HSA_ADDR, 8'hFF);
        rd(`HSA_ADDR, 8'h77);
        wr(7'h11, 8'hFF);
        rd(7'h11, 8'h00);
        // Each code in low then high fields; first_cyclic_timer high, second_cyclic_timer low
        for (int p = 0; p < 2; p++) begin
            for (int c = 0; c < 8; c++) begin
                v = p ? {1'b0, 3'(c), 4'h0} : {5'h00, 3'(c)};
                e = 1'(8'h16 >> c);
                wr(`HSA_ADDR, v);
                wr(`HSB_ADDR, v);
                settle();
                check("switchOut", {4'h0, switchOut}, p ? {4'h0, e, 1'b0, e, 1'b0} : {4'h0, 1'b0, e, 1'b0, e});
            end
        end
        // Timer that is not running keeps its switch low
        @(posedge clk);
        timer1OnCode <= 3'h0;
        wr(`HSA_ADDR, 8'h02);
        wr(`HSB_ADDR, 8'h20);
        settle();
        check("switchOut", {4'h0, switchOut}, 8'h00);
        // Mid duty value: on for duty/255 of each 255-step period
        wr(`HSA_ADDR, 8'h04);
        duty1 <= 8'h33;
        settle();
        cnt = 8'h00;
        repeat (255) begin
            @(posedge clk);
            #1 cnt = cnt + 8'(switchOut[0]);
        end
        check("dutyOnSteps", cnt, 8'h33);
        // Pin modes, pin 2 driven with the mirrored code
        for (int c = 0; c < 8; c++) begin
            d = 7 - c;
            wr(`MPC_ADDR, {2'b00, 3'(d), 3'(c)});
            settle();
            check("pinModes", {1'b0, pin1Fault, pin1Wake, pin1LowSide, pin1HighSide, pin2Wake, pin2LowSide, pin2HighSide}, {1'b0, c < 4, c == 5, c == 6, c == 7, d == 5, d == 6, d == 7});
        end
        // Fault-output duty: on-steps in one 40-step period
        faultLevel3 <= 1'b1;
        for (int k = 0; k < 4; k++) begin
            wr(`MPC_ADDR, {2'(k), 6'h04});
            repeat (45) @(posedge clk);
            cnt = 8'h00;
            repeat (40) begin
                @(posedge clk);
                #1 cnt = cnt + 8'(pin2Fault);
            end
            check("foOnSteps", cnt, 8'h08 >> k);
        end
        // Supply faults against the three control bits
        supply_case(8'h00, 1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
        supply_case(8'h40, 1'b1, 1'b0, 8'h01, 1'b1, 1'b1);
        supply_case(8'h00, 1'b0, 1'b1, 8'h00, 1'b0, 1'b0);
        supply_case(8'h20, 1'b0, 1'b1, 8'h01, 1'b1, 1'b1);
        supply_case(8'h10, 1'b1, 1'b0, 8'h01, 1'b0, 1'b1);
        supply_case(8'h50, 1'b0, 1'b1, 8'h01, 1'b0, 1'b1);
        // Short on switch 3 clears only its own field
        wr(`HSB_ADDR, 8'h11);
        @(posedge clk);
        shortCmd <= 4'h4;
        settle();
        rd(`HSB_ADDR, 8'h10);
        check("switchOut", {4'h0, switchOut}, 8'h08);
        shortCmd <= 4'h0;
        // Restart keeps shutdown and pin bits, soft reset clears all
        wr(`SSC_ADDR, 8'h70);
        wr(`HSA_ADDR, 8'h11);
        wr(`MPC_ADDR, 8'h5A);
        @(posedge clk);
        restartReq <= 1'b1;
        @(posedge clk);
        restartReq <= 1'b0;
        rd(`SSC_ADDR, 8'h70);
        rd(`HSA_ADDR, 8'h00);
        rd(`MPC_ADDR, 8'h5A);
        @(posedge clk);
        softReset <= 1'b1;
        @(posedge clk);
        softReset <= 1'b0;
        all_zero();
        results();
    end
endmodule // tb_top
